// >>> verilog/port_clock_gate_regs.svh
// Register offsets, field positions and reset values of the gating and soft reset bank
// Function
// - Each of the six port gate bits, 5 down to 0 for ports F to A, clocks its port while set.
// - A bus access aimed at a port whose gate is clear is answered with a bus fault.
// - Every port gate bit is read/write and comes out of reset at 0, so each port starts unclocked.
// - Soft reset control word zero sits at offset 0x040 and resets to 0x00000000.
// - Writes to soft reset control word zero are filtered by the capability bits.
// - Bit 20 of soft reset control word zero is a read/write reset for the pulse-width modulator.
// - Bit 16 of soft reset control word zero is a read/write reset for converter module 0.
// - Bit 6 of soft reset control word zero is a read/write reset for the hibernation module.
// - Bit 3 of soft reset control word zero is a read/write reset for the watchdog unit.
// - The unused fields of soft reset control word zero are read-only and read as zero.
// - The deep-sleep port gate register acts only in deep sleep; run and sleep gates rule elsewhere.
// - Sleep and deep-sleep gating apply only while the automatic clock gating bit is set.
`ifndef PORT_CLOCK_GATE_REGS_SVH
`define PORT_CLOCK_GATE_REGS_SVH

// Byte offsets inside the system control space
`define SRCR_OFF 12'h040
`define RUNCFG_OFF 12'h060
`define DSGATE_OFF 12'h128
`define IRQ_STAT_OFF 12'h150
`define IRQ_MASK_OFF 12'h154

// Reset values
`define SRCR_RESET 32'h00000000
`define DSGATE_RESET 32'h00000000
`define RUNCFG_RESET 32'h00000000
`define IRQ_RESET 32'h00000000

// Writable fields
`define SRCR_RW_MASK 32'h00110048
`define DSGATE_RW_MASK 32'h0000003F
`define RUNCFG_RW_MASK 32'h00000001
`define IRQ_RW_MASK 32'h00000003

// Field positions
`define PWM_RST_BIT 20
`define ADC_RST_BIT 16
`define HIBERNATE_RST_BIT 6
`define WATCHDOG_RST_BIT 3
`define AUTO_GATE_BIT 0
`define IRQ_FAULT_BIT 0
`define IRQ_FILTER_BIT 1
`define NUM_PORTS 6

`endif

// >>> verilog/port_clock_gate_pkg.sv
// Types shared by the gating and soft reset bank
package port_clock_gate_pkg;

  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_SLEEP = 2'b01,
    MODE_DEEP = 2'b10
  } power_mode_t;

  typedef enum logic {
    WB_IDLE = 1'b0,
    WB_DONE = 1'b1
  } wb_state_t;

endpackage : port_clock_gate_pkg

// >>> verilog/port_gate_select.sv
// Selection of the effective port clock enables from the power mode
`timescale 1ns/1ps
`default_nettype none
`include "port_clock_gate_regs.svh"
module port_gate_select
  import port_clock_gate_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Mode and gate sources
  input wire logic [1:0] power_mode_i,
  input wire logic auto_clock_gating_enable_i,
  input wire logic [5:0] run_gates_i,
  input wire logic [5:0] sleep_gates_i,
  input wire logic [5:0] deep_gates_i,
  // Effective enables
  output logic [5:0] port_clk_en_o
);

  wire logic [5:0] next_port_clk_en;
  wire logic in_sleep;
  wire logic in_deep;

  assign in_sleep = (power_mode_i == MODE_SLEEP) && auto_clock_gating_enable_i;
  assign in_deep = (power_mode_i == MODE_DEEP) && auto_clock_gating_enable_i;
  assign next_port_clk_en = in_deep ? deep_gates_i : (in_sleep ? sleep_gates_i : run_gates_i);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      port_clk_en_o <= 6'h00;
    end else begin
      port_clk_en_o <= next_port_clk_en;
    end
  end

endmodule : port_gate_select
`default_nettype wire

// >>> verilog/port_access_guard.sv
// Bus fault guard for accesses to gated ports
`timescale 1ns/1ps
`default_nettype none
`include "port_clock_gate_regs.svh"
module port_access_guard (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Port access request
  input wire logic port_req_i,
  input wire logic [2:0] port_idx_i,
  input wire logic [5:0] port_clk_en_i,
  // Answer
  output logic port_grant_o,
  output logic port_fault_o
);

  wire logic idx_valid;
  wire logic port_open;

  assign idx_valid = port_idx_i < 3'h6;
  assign port_open = idx_valid && port_clk_en_i[port_idx_i];

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      port_grant_o <= 1'b0;
      port_fault_o <= 1'b0;
    end else begin
      port_grant_o <= port_req_i && port_open;
      port_fault_o <= port_req_i && !port_open;
    end
  end

endmodule : port_access_guard
`default_nettype wire

// >>> verilog/port_clock_gate_and_soft_reset.sv
// Deep-sleep port clock gates and soft reset control word zero behind a Wishbone slave
`timescale 1ns/1ps
`default_nettype none
`include "port_clock_gate_regs.svh"
module port_clock_gate_and_soft_reset
  import port_clock_gate_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // Power state and other gate sources
  input wire logic [1:0] power_mode_i,
  input wire logic [5:0] run_port_gates_i,
  input wire logic [5:0] sleep_port_gates_i,
  input wire logic [31:0] capability_word_one_i,
  // Port access path
  input wire logic port_req_i,
  input wire logic [2:0] port_idx_i,
  output logic port_grant_o,
  output logic port_fault_o,
  // Port clock enables, F down to A
  output logic [5:0] port_clk_en_o,
  // Peripheral resets
  output logic pwm_reset_o,
  output logic adc0_reset_o,
  output logic hibernation_reset_ctl_o,
  output logic watchdog_reset_ctl_o,
  // Interrupt
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [31:0] soft_reset_control_word_zero;
  logic [31:0] deep_sleep_port_clock_gates;
  logic [31:0] run_mode_clock_config;
  logic [31:0] irq_status;
  logic [31:0] irq_mask;
  wb_state_t wb_state;
  logic [31:0] next_wb_dat;
  logic next_wb_err;

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode and write data

  wire logic [11:0] word_adr;
  wire logic hit_srcr;
  wire logic hit_dsgate;
  wire logic hit_runcfg;
  wire logic hit_stat;
  wire logic hit_mask;
  wire logic hit_any;
  wire logic req_new;
  wire logic commit;
  wire logic [31:0] byte_mask;
  wire logic [31:0] srcr_merged;
  wire logic [31:0] srcr_written;
  wire logic [31:0] dsgate_written;
  wire logic [31:0] runcfg_written;
  wire logic [31:0] mask_written;
  wire logic [31:0] stat_clear;
  wire logic [31:0] stat_set;
  wire logic filter_hit;
  wire logic auto_clock_gating_enable;

  assign word_adr = {wb_adr_i[11:2], 2'h0};
  // control word zero at its offset
  assign hit_srcr = word_adr == `SRCR_OFF;
  assign hit_dsgate = word_adr == `DSGATE_OFF;
  assign hit_runcfg = word_adr == `RUNCFG_OFF;
  assign hit_stat = word_adr == `IRQ_STAT_OFF;
  assign hit_mask = word_adr == `IRQ_MASK_OFF;
  assign hit_any = hit_srcr || hit_dsgate || hit_runcfg || hit_stat || hit_mask;

  assign req_new = wb_cyc_i && wb_stb_i && (wb_state == WB_IDLE);
  // A write lands on the edge at which the master samples ack
  assign commit = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

  assign byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  assign srcr_merged = (soft_reset_control_word_zero & ~byte_mask) | (wb_dat_i & byte_mask);
  assign srcr_written = ((srcr_merged & capability_word_one_i)
                        | (soft_reset_control_word_zero & ~capability_word_one_i))
                        & `SRCR_RW_MASK;
  assign filter_hit = commit && hit_srcr
                      && (((srcr_merged ^ soft_reset_control_word_zero)
                      & ~capability_word_one_i & `SRCR_RW_MASK) != 32'h00000000);

  assign dsgate_written = ((deep_sleep_port_clock_gates & ~byte_mask) | (wb_dat_i & byte_mask))
                          & `DSGATE_RW_MASK;
  assign runcfg_written = ((run_mode_clock_config & ~byte_mask) | (wb_dat_i & byte_mask))
                          & `RUNCFG_RW_MASK;
  assign mask_written = ((irq_mask & ~byte_mask) | (wb_dat_i & byte_mask)) & `IRQ_RW_MASK;

  // Write one to clear; a new event in the same cycle wins over the clear
  assign stat_clear = (commit && hit_stat) ? (wb_dat_i & byte_mask) : 32'h00000000;
  assign stat_set = ({31'h00000000, port_fault_o} << `IRQ_FAULT_BIT)
                    | ({31'h00000000, filter_hit} << `IRQ_FILTER_BIT);

  assign auto_clock_gating_enable = run_mode_clock_config[`AUTO_GATE_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux

  always_comb begin
    next_wb_dat = 32'h00000000;
    // Unmapped addresses end with err rather than a silent ack
    next_wb_err = !hit_any;
    if (hit_srcr) begin
      next_wb_dat = soft_reset_control_word_zero;
    end else if (hit_dsgate) begin
      next_wb_dat = deep_sleep_port_clock_gates;
    end else if (hit_runcfg) begin
      next_wb_dat = run_mode_clock_config;
    end else if (hit_stat) begin
      next_wb_dat = irq_status;
    end else if (hit_mask) begin
      next_wb_dat = irq_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus handshake

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wb_state <= WB_IDLE;
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      case (wb_state)
        WB_IDLE: begin
          if (req_new) begin
            wb_state <= WB_DONE;
            wb_ack_o <= !next_wb_err;
            wb_err_o <= next_wb_err;
            wb_dat_o <= next_wb_dat;
          end
        end
        WB_DONE: begin
          wb_state <= WB_IDLE;
          wb_ack_o <= 1'b0;
          wb_err_o <= 1'b0;
        end
        default: begin
          wb_state <= WB_IDLE;
          wb_ack_o <= 1'b0;
          wb_err_o <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register storage

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      soft_reset_control_word_zero <= `SRCR_RESET;
    end else if (commit && hit_srcr) begin
      soft_reset_control_word_zero <= srcr_written;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      deep_sleep_port_clock_gates <= `DSGATE_RESET;
      run_mode_clock_config <= `RUNCFG_RESET;
      irq_mask <= `IRQ_RESET;
    end else begin
      if (commit && hit_dsgate) begin
        deep_sleep_port_clock_gates <= dsgate_written;
      end
      if (commit && hit_runcfg) begin
        run_mode_clock_config <= runcfg_written;
      end
      if (commit && hit_mask) begin
        irq_mask <= mask_written;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_status <= `IRQ_RESET;
      irq_o <= 1'b0;
    end else begin
      irq_status <= ((irq_status & ~stat_clear) | stat_set) & `IRQ_RW_MASK;
      irq_o <= |(irq_status & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Peripheral resets

  // held while the bit is set
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pwm_reset_o <= 1'b0;
      adc0_reset_o <= 1'b0;
      hibernation_reset_ctl_o <= 1'b0;
      watchdog_reset_ctl_o <= 1'b0;
    end else begin
      pwm_reset_o <= soft_reset_control_word_zero[`PWM_RST_BIT];
      adc0_reset_o <= soft_reset_control_word_zero[`ADC_RST_BIT];
      hibernation_reset_ctl_o <= soft_reset_control_word_zero[`HIBERNATE_RST_BIT];
      watchdog_reset_ctl_o <= soft_reset_control_word_zero[`WATCHDOG_RST_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Gate selection and access guard

  // deep-sleep register only in deep sleep
  port_gate_select u_gate_select (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .power_mode_i(power_mode_i),
    .auto_clock_gating_enable_i(auto_clock_gating_enable),
    .run_gates_i(run_port_gates_i),
    .sleep_gates_i(sleep_port_gates_i),
    .deep_gates_i(deep_sleep_port_clock_gates[5:0]),
    .port_clk_en_o(port_clk_en_o)
  );

  port_access_guard u_access_guard (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .port_req_i(port_req_i),
    .port_idx_i(port_idx_i),
    .port_clk_en_i(port_clk_en_o),
    .port_grant_o(port_grant_o),
    .port_fault_o(port_fault_o)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  chk_deep_gate_follow: assert property (
    (power_mode_i == MODE_DEEP && auto_clock_gating_enable)
    |=> port_clk_en_o == $past(deep_sleep_port_clock_gates[5:0]))
  else $error("deep sleep enables do not follow gate register");

  chk_run_gate_follow: assert property (
    (power_mode_i == MODE_RUN) |=> port_clk_en_o == $past(run_port_gates_i))
  else $error("run mode enables do not follow run gates");

  chk_auto_gate_off: assert property (
    (power_mode_i != MODE_RUN && !auto_clock_gating_enable)
    |=> port_clk_en_o == $past(run_port_gates_i))
  else $error("sleep gating applied without automatic gating");

  chk_closed_port_fault: assert property (
    (port_req_i && port_idx_i < 3'h6 && !port_clk_en_o[port_idx_i])
    |=> port_fault_o && !port_grant_o)
  else $error("access to gated port not faulted");

  chk_open_port_grant: assert property (
    (port_req_i && port_idx_i < 3'h6 && port_clk_en_o[port_idx_i])
    |=> port_grant_o && !port_fault_o)
  else $error("access to clocked port faulted");

  chk_gate_reset_zero: assert property (
    $fell(rst_i) |-> deep_sleep_port_clock_gates == 32'h00000000 && port_clk_en_o == 6'h00)
  else $error("gates not zero after reset");

  chk_srcr_unused_zero: assert property (
    (soft_reset_control_word_zero & ~`SRCR_RW_MASK) == 32'h00000000)
  else $error("unused control bits not zero");

  chk_cap_filter_hold: assert property (
    ##1 (((soft_reset_control_word_zero ^ $past(soft_reset_control_word_zero))
    & ~$past(capability_word_one_i)) == 32'h00000000))
  else $error("absent peripheral reset bit changed");

  chk_pwm_reset_write: assert property (
    (commit && hit_srcr && wb_sel_i[2] && wb_dat_i[`PWM_RST_BIT]
    && capability_word_one_i[`PWM_RST_BIT]) |=> ##1 pwm_reset_o)
  else $error("pwm reset not asserted after write");

  chk_reset_hold_map: assert property (
    ##1 {pwm_reset_o, adc0_reset_o, hibernation_reset_ctl_o, watchdog_reset_ctl_o}
    == $past({soft_reset_control_word_zero[`PWM_RST_BIT],
    soft_reset_control_word_zero[`ADC_RST_BIT],
    soft_reset_control_word_zero[`HIBERNATE_RST_BIT],
    soft_reset_control_word_zero[`WATCHDOG_RST_BIT]}))
  else $error("peripheral reset does not match control word");

  chk_ack_single_pulse: assert property (
    (wb_ack_o || wb_err_o) |=> !wb_ack_o && !wb_err_o)
  else $error("bus answer longer than one cycle");

  cov_deep_gated_fault: cover property (
    power_mode_i == MODE_DEEP && auto_clock_gating_enable ##1 port_fault_o);
  cov_srcr_write: cover property (commit && hit_srcr);
  cov_irq_raise: cover property ($rose(irq_o));
  cov_filter_event: cover property (filter_hit);

endmodule : port_clock_gate_and_soft_reset
`default_nettype wire

// >>> tb/wb_host_model.sv
// Wishbone host model standing in for the processor core
`timescale 1ns/1ps
`default_nettype none
module wb_host_model (
  // Clock
  input wire logic sys_clk_i,
  // Wishbone master side
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [11:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_i,
  input wire logic wb_err_i
);
  initial begin
    wb_cyc_o = 1'h0;
    wb_stb_o = 1'h0;
    wb_we_o = 1'h0;
    wb_adr_o = 12'h000;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h00000000;
  end
  // One classic cycle; a dead slave is left to the bench timeout
  task automatic access(input logic we, input logic [11:0] adr, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
    @(posedge sys_clk_i);
    wb_cyc_o <= 1'h1;
    wb_stb_o <= 1'h1;
    wb_we_o <= we;
    wb_adr_o <= adr;
    wb_sel_o <= 4'hF;
    wb_dat_o <= wd;
    do begin
      @(posedge sys_clk_i);
    end while (wb_ack_i !== 1'h1 && wb_err_i !== 1'h1);
    rd = wb_dat_i;
    err = wb_err_i;
    wb_cyc_o <= 1'h0;
    wb_stb_o <= 1'h0;
    // Released data is inverted so nothing can lean on a stale value
    wb_dat_o <= ~wd;
  endtask : access
endmodule : wb_host_model
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the port gate and soft reset register bank
`timescale 1ns/1ps
`default_nettype none
`include "port_clock_gate_regs.svh"
module testbench import port_clock_gate_pkg::*;;
  logic sys_clk_i, rst_i, cyc, stb, we, ack, err, req, grant, fault, irq;
  logic pwm_r, adc_r, hibernate_r, watchdog_r;
  logic [11:0] adr;
  logic [3:0] sel;
  logic [31:0] dw, dr, cap;
  logic [1:0] mode;
  logic [5:0] run_g, sleep_g, clk_en;
  logic [2:0] idx;
  int fail_count, samples_checked;
  int cycles = 0;
  wire logic [31:0] rst_vec = {11'h0, pwm_r, 3'h0, adc_r, 9'h0, hibernate_r, 2'h0, watchdog_r,
    3'h0};

  initial begin
    sys_clk_i = 1'h0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  wb_host_model wb_host_model_i (.sys_clk_i(sys_clk_i), .wb_cyc_o(cyc), .wb_stb_o(stb),
    .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(dw), .wb_dat_i(dr),
    .wb_ack_i(ack), .wb_err_i(err));

  port_clock_gate_and_soft_reset port_clock_gate_and_soft_reset_i (.sys_clk_i(sys_clk_i),
    .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .wb_err_o(err),
    .power_mode_i(mode), .run_port_gates_i(run_g), .sleep_port_gates_i(sleep_g),
    .capability_word_one_i(cap), .port_req_i(req), .port_idx_i(idx),
    .port_grant_o(grant), .port_fault_o(fault), .port_clk_en_o(clk_en),
    .pwm_reset_o(pwm_r), .adc0_reset_o(adc_r), .hibernation_reset_ctl_o(hibernate_r),
    .watchdog_reset_ctl_o(watchdog_r), .irq_o(irq));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    wb_host_model_i.access(1'h1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    logic e;
    wb_host_model_i.access(1'h0, a, 32'h00000000, d, e);
  endtask : rd

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    cmp(d, exp, "read");
  endtask : rd_chk

  // Registered outputs lag the committing edge, so give them time to land
  task automatic settle;
    repeat (3) @(posedge sys_clk_i);
  endtask : settle

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd_chk(`SRCR_OFF, `SRCR_RESET);
    rd_chk(`DSGATE_OFF, `DSGATE_RESET);
    cmp({26'h0, clk_en}, 32'h00000000, "gates");
    cmp(rst_vec, 32'h00000000, "resets");
  endtask : t_reset

  task automatic t_reset_bits;
    logic [31:0] d;
    for (int b = 0; b < 32; b++) begin
      wr(`SRCR_OFF, 32'h00000001 << b);
      rd_chk(`SRCR_OFF, (32'h00000001 << b) & `SRCR_RW_MASK);
      settle;
      cmp(rst_vec, (32'h00000001 << b) & `SRCR_RW_MASK, "reset out");
    end
    wr(`SRCR_OFF, 32'hFFFFFFFF);
    wr(`SRCR_OFF, 32'h00000000);
    settle;
    cmp(rst_vec, 32'h00000000, "release");
    // Read-modify-write that keeps whatever the other bits hold
    rd(`SRCR_OFF, d);
    wr(`SRCR_OFF, d | 32'h00000040);
    rd_chk(`SRCR_OFF, 32'h00000040);
    wr(`SRCR_OFF, 32'h00000000);
  endtask : t_reset_bits

  task automatic t_filter;
    wr(`SRCR_OFF, 32'h00100000);
    @(posedge sys_clk_i);
    cap <= 32'h00000008;
    wr(`SRCR_OFF, 32'h00010048);
    rd_chk(`SRCR_OFF, 32'h00100008);
    rd_chk(`IRQ_STAT_OFF, 32'h00000002);
    settle;
    cmp({31'h0, irq}, 32'h00000000, "irq masked");
    wr(`IRQ_MASK_OFF, 32'h00000002);
    settle;
    cmp({31'h0, irq}, 32'h00000001, "irq up");
    wr(`IRQ_STAT_OFF, 32'h00000002);
    settle;
    cmp({31'h0, irq}, 32'h00000000, "irq cleared");
    @(posedge sys_clk_i);
    cap <= 32'hFFFFFFFF;
    wr(`SRCR_OFF, 32'h00000000);
  endtask : t_filter

  task automatic t_gates;
    logic [5:0] e;
    @(posedge sys_clk_i);
    run_g <= 6'h2A;
    sleep_g <= 6'h0C;
    wr(`DSGATE_OFF, 32'hFFFFFFFF);
    rd_chk(`DSGATE_OFF, `DSGATE_RW_MASK);
    wr(`DSGATE_OFF, 32'h00000015);
    for (int g = 0; g < 2; g++) begin
      wr(`RUNCFG_OFF, g);
      for (int m = 0; m < 4; m++) begin
        @(posedge sys_clk_i);
        mode <= 2'(m);
        settle;
        e = (g == 1 && m == 2) ? 6'h15 : (g == 1 && m == 1) ? 6'h0C : 6'h2A;
        cmp({26'h0, clk_en}, {26'h0, e}, "gate sel");
      end
    end
    @(posedge sys_clk_i);
    mode <= MODE_RUN;
  endtask : t_gates

  task automatic port_try(input logic [2:0] i, input logic ok);
    @(posedge sys_clk_i);
    req <= 1'h1;
    idx <= i;
    @(posedge sys_clk_i);
    req <= 1'h0;
    @(posedge sys_clk_i);
    cmp({30'h0, grant, fault}, {30'h0, ok, ~ok}, "port answer");
  endtask : port_try

  task automatic t_ports;
    logic [31:0] d;
    logic e;
    settle;
    for (int i = 0; i < 8; i++)
      port_try(3'(i), i < 6 && run_g[i]);
    rd_chk(`IRQ_STAT_OFF, 32'h00000001);
    wr(`IRQ_MASK_OFF, 32'h00000001);
    settle;
    cmp({31'h0, irq}, 32'h00000001, "fault irq");
    wr(`IRQ_STAT_OFF, 32'h00000001);
    settle;
    cmp({31'h0, irq}, 32'h00000000, "fault clr");
    wb_host_model_i.access(1'h1, 12'h3FC, 32'hFFFFFFFF, d, e);
    cmp({31'h0, e}, 32'h00000001, "unmapped err");
    wb_host_model_i.access(1'h0, 12'h3FC, 32'h00000000, d, e);
    cmp(d, 32'h00000000, "unmapped data");
  endtask : t_ports

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      $display("FAIL t=%0t timeout", $time);
      give_verdict;
    end
  end

  initial begin
    fail_count = 0;
    samples_checked = 0;
    rst_i = 1'h1;
    cap = 32'hFFFFFFFF;
    mode = 2'h0;
    run_g = 6'h00;
    sleep_g = 6'h00;
    req = 1'h0;
    idx = 3'h0;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'h0;
    @(posedge sys_clk_i);
    t_reset;
    t_reset_bits;
    t_filter;
    t_gates;
    t_ports;
    give_verdict;
  end
endmodule : testbench
`default_nettype wire
